// file: include/ltps_regs.svh
// Register offsets, field positions, reset values and counts of the line test pattern selector.
// Assumes byte addressing on a 32-bit APB bus; each register is one aligned word.
`ifndef LTPS_REGS_SVH
`define LTPS_REGS_SVH

// Register byte offsets
`define LTPS_CTRL_OFS        8'h00
`define LTPS_STATUS_OFS      8'h04
`define LTPS_INT_STAT_OFS    8'h08
`define LTPS_INT_CLR_OFS     8'h0C
`define LTPS_INT_EN_OFS      8'h10

// Control register fields
`define LTPS_ALT_RATE_BIT    7
`define LTPS_SONET_BIT       6
`define LTPS_SEL_HI_BIT      3
`define LTPS_SEL_LO_BIT      2

// Status and interrupt fields
`define LTPS_DET_BIT         0
`define LTPS_EV_GAIN_BIT     0
`define LTPS_EV_LOSS_BIT     1
`define LTPS_EV_MODE_BIT     2
`define LTPS_EV_W            3

// Reset values
`define LTPS_CTRL_RST        1'b0
`define LTPS_INT_RST         3'h0

// Detector counts and DS3 alarm framing sizes
`define LTPS_SYNC_GOOD       48
`define LTPS_LOSS_ERRS       8
`define LTPS_AIS_BLOCK       7'd84
`define LTPS_AIS_P_BIT       1'b1

`endif

// file: include/ltps_pkg.sv
// Types of the line test pattern selector: rate modes and the module state record.
// Assumes ltps_regs.svh is included by the user of the package where constants are needed.
package ltps_pkg;

    // Line rate derived from the two mode bits
    typedef enum logic [1:0] {LTPS_DS3, LTPS_E3, LTPS_STS1} ltps_rate_t;

    // Whole state of the selector
    typedef struct packed {
        logic [1:0]  sync_pos;
        logic [1:0]  sync_neg;
        logic [1:0]  sync_rx;
        logic        alt_rate_enable;
        logic        sonet_rate_select;
        logic        tx_source_sel_hi;
        logic        tx_source_sel_lo;
        logic [2:0]  int_stat;
        logic [2:0]  int_en;
        logic [31:0] rdata;
        logic        tx_pos;
        logic        tx_neg;
        logic [1:0]  phase3;
        logic [6:0]  ais_bit;
        logic [2:0]  ais_blk;
        logic [2:0]  ais_sub;
        logic [22:0] gen;
        logic [22:0] hist;
        logic [5:0]  good;
        logic [3:0]  errs;
        logic        locked;
    } ltps_state_t;

endpackage : ltps_pkg

// file: src/ltps_top.sv
// Transmit data source selector and receive PRBS detector for one line port, with APB registers.
// Assumes framer rails and receive data arrive as pins sampled on pclk, one bit per clock.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ltps_regs.svh"

module ltps_top
    import ltps_pkg::*;
#(
    parameter int SYNC_GOOD     = `LTPS_SYNC_GOOD,
    parameter int LOSS_ERRS     = `LTPS_LOSS_ERRS,
    parameter bit STS1_LONG_POLY = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_positive_rail,
    input  wire logic        tx_negative_rail,
    input  wire logic        rx_line_data,
    output logic             line_tx_pos,
    output logic             line_tx_neg,
    output logic             pattern_detect_out,
    output logic             irq
);

    ltps_state_t st;
    ltps_state_t next_st;

    logic       setup;
    logic       wr_acc;
    logic       mapped;
    ltps_rate_t rate;
    logic       long_poly;
    logic       gen_fb;
    logic       gen_zero;
    logic       rx_bit;
    logic       rx_pred;
    logic       match;
    logic       ais_out;
    logic [2:0] ev;
    logic       rate_chg;

    // Address decode and bus phases
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign mapped = (paddr == `LTPS_CTRL_OFS) || (paddr == `LTPS_STATUS_OFS) ||
                    (paddr == `LTPS_INT_STAT_OFS) || (paddr == `LTPS_INT_CLR_OFS) ||
                    (paddr == `LTPS_INT_EN_OFS);
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = st.rdata;

    // A control write that moves either rate bit
    assign rate_chg = wr_acc && (paddr == `LTPS_CTRL_OFS) &&
                      ((pwdata[`LTPS_ALT_RATE_BIT] != st.alt_rate_enable) ||
                       (pwdata[`LTPS_SONET_BIT] != st.sonet_rate_select));

    // Rate decode: DS3 unless alt rate set, then sonet bit picks E3 or STS-1
    always_comb begin
        if (!st.alt_rate_enable) begin
            rate = LTPS_DS3;
        end else if (st.sonet_rate_select) begin
            rate = LTPS_STS1;
        end else begin
            rate = LTPS_E3;
        end
    end

    // Polynomial choice shared by generator and detector
    always_comb begin
        case (rate)
            LTPS_DS3:  long_poly = 1'b0;
            LTPS_E3:   long_poly = 1'b1;
            LTPS_STS1: long_poly = STS1_LONG_POLY;
            default:   long_poly = 1'b1;
        endcase
    end

    // Generator feedback; an all-zero register is kicked out of lockup
    assign gen_zero = long_poly ? (st.gen == 23'h000000) : (st.gen[14:0] == 15'h0000);
    assign gen_fb   = (long_poly ? (st.gen[22] ^ st.gen[17]) : (st.gen[14] ^ st.gen[13]))
                      | gen_zero;

    // Detector predicts each bit from the last received ones; PRBS patterns are sent inverted
    assign rx_bit  = ~st.sync_rx[1];
    assign rx_pred = long_poly ? (st.hist[22] ^ st.hist[17]) : (st.hist[14] ^ st.hist[13]);
    assign match   = (rx_bit == rx_pred);

    // DS3 alarm frame: 85-bit blocks, 8 per subframe, 7 subframes, payload 1010
    always_comb begin
        if (st.ais_bit != 7'd0) begin
            ais_out = st.ais_bit[0];
        end else begin
            case (st.ais_blk)
                3'd0: begin
                    case (st.ais_sub)
                        3'd0, 3'd1: ais_out = 1'b1;
                        3'd2, 3'd3: ais_out = `LTPS_AIS_P_BIT;
                        3'd5:       ais_out = 1'b1;
                        default:    ais_out = 1'b0;
                    endcase
                end
                3'd1, 3'd7: ais_out = 1'b1;
                3'd3, 3'd5: ais_out = 1'b0;
                default:    ais_out = 1'b0;
            endcase
        end
    end

    // Next state of the whole block
    always_comb begin
        next_st = st;
        ev      = 3'h0;

        // Two-stage sampling of the pins
        next_st.sync_pos = {st.sync_pos[0], tx_positive_rail};
        next_st.sync_neg = {st.sync_neg[0], tx_negative_rail};
        next_st.sync_rx  = {st.sync_rx[0], rx_line_data};

        // Register writes take effect at the access edge
        if (wr_acc && paddr == `LTPS_CTRL_OFS) begin
            if (rate_chg && (st.tx_source_sel_hi | st.tx_source_sel_lo)) begin
                ev[`LTPS_EV_MODE_BIT] = 1'b1;
            end
            next_st.alt_rate_enable   = pwdata[`LTPS_ALT_RATE_BIT];
            next_st.sonet_rate_select = pwdata[`LTPS_SONET_BIT];
            next_st.tx_source_sel_hi  = pwdata[`LTPS_SEL_HI_BIT];
            next_st.tx_source_sel_lo  = pwdata[`LTPS_SEL_LO_BIT];
        end
        if (wr_acc && paddr == `LTPS_INT_EN_OFS) begin
            next_st.int_en = pwdata[`LTPS_EV_W-1:0];
        end

        // Read data latched in the setup cycle
        if (setup) begin
            case (paddr)
                `LTPS_CTRL_OFS: next_st.rdata = {24'h000000, st.alt_rate_enable,
                    st.sonet_rate_select, 2'b00, st.tx_source_sel_hi,
                    st.tx_source_sel_lo, 2'b00};
                `LTPS_STATUS_OFS:   next_st.rdata = {31'h00000000, st.locked};
                `LTPS_INT_STAT_OFS: next_st.rdata = {29'h00000000, st.int_stat};
                `LTPS_INT_EN_OFS:   next_st.rdata = {29'h00000000, st.int_en};
                default:            next_st.rdata = 32'h00000000;
            endcase
        end

        // Pattern generators run freely
        next_st.phase3 = (st.phase3 == 2'd2) ? 2'd0 : st.phase3 + 2'd1;
        next_st.gen    = {st.gen[21:0], gen_fb};
        if (st.ais_bit == `LTPS_AIS_BLOCK) begin
            next_st.ais_bit = 7'd0;
            if (st.ais_blk == 3'd7) begin
                next_st.ais_sub = (st.ais_sub == 3'd6) ? 3'd0 : st.ais_sub + 3'd1;
            end
            next_st.ais_blk = st.ais_blk + 3'd1;
        end else begin
            next_st.ais_bit = st.ais_bit + 7'd1;
        end

        // Transmit source selection
        next_st.tx_neg = 1'b0;
        case ({st.tx_source_sel_hi, st.tx_source_sel_lo})
            2'b00: begin
                next_st.tx_pos = st.sync_pos[1];
                next_st.tx_neg = st.sync_neg[1];
            end
            2'b01: begin
                // The low bit alone sends the alarm at DS3 with the sonet bit set, all ones otherwise
                next_st.tx_pos = (rate == LTPS_DS3 && st.sonet_rate_select) ? ais_out
                                                                            : 1'b1;
            end
            2'b10:   next_st.tx_pos = (st.phase3 == 2'd0);
            2'b11:   next_st.tx_pos = ~gen_fb;
            default: next_st.tx_pos = 1'b0;
        endcase

        // Receive detector: hunt, then hold until too many errors
        next_st.hist = {st.hist[21:0], rx_bit};
        if (rate_chg) begin
            // Rate write wins, so no lock is ever taken with the old polynomial
            next_st.locked = 1'b0;
            next_st.good   = 6'h00;
            next_st.errs   = 4'h0;
        end else if (!st.locked) begin
            if (!match) begin
                next_st.good = 6'h00;
            end else if (st.good == 6'(SYNC_GOOD - 1)) begin
                next_st.locked = 1'b1;
                next_st.good   = 6'h00;
                next_st.errs   = 4'h0;
                ev[`LTPS_EV_GAIN_BIT] = 1'b1;
            end else begin
                next_st.good = st.good + 6'h01;
            end
        end else if (!match) begin
            if (st.errs == 4'(LOSS_ERRS - 1)) begin
                next_st.locked = 1'b0;
                next_st.errs   = 4'h0;
                next_st.good   = 6'h00;
                ev[`LTPS_EV_LOSS_BIT] = 1'b1;
            end else begin
                next_st.errs = st.errs + 4'h1;
            end
        end else if (st.good == 6'(SYNC_GOOD - 1)) begin
            next_st.good = 6'h00; // SYNC_GOOD matching bits, errors among them allowed, forgive old errors
            next_st.errs = 4'h0;
        end else begin
            next_st.good = st.good + 6'h01;
        end

        // Sticky events: set wins over a write-one clear in the same cycle
        if (wr_acc && paddr == `LTPS_INT_CLR_OFS) begin
            next_st.int_stat = st.int_stat & ~pwdata[`LTPS_EV_W-1:0];
        end
        next_st.int_stat = next_st.int_stat | ev;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st                   <= '0;
            st.alt_rate_enable   <= `LTPS_CTRL_RST;
            st.sonet_rate_select <= `LTPS_CTRL_RST;
            st.tx_source_sel_hi  <= `LTPS_CTRL_RST;
            st.tx_source_sel_lo  <= `LTPS_CTRL_RST;
            st.int_stat          <= `LTPS_INT_RST;
            st.int_en            <= `LTPS_INT_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign line_tx_pos        = st.tx_pos;
    assign line_tx_neg        = st.tx_neg;
    assign pattern_detect_out = st.locked;
    assign irq                = |(st.int_stat & st.int_en);

endmodule : ltps_top

// file: testbench/ltps_framer_model.sv
// Framer-side partner: sends an inverted PRBS stream on the receive line.
// Assumes one bit per pclk; err flips the bit sent in that cycle.
`timescale 1ns/1ps
module ltps_framer_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic long_poly,
    input  wire logic err,
    output logic      rx_line_data
);
    logic [22:0] sr;
    logic        nb;
    // Feedback taps of the 15-bit or the 23-bit sequence
    assign nb = long_poly ? sr[22] ^ sr[17] : sr[14] ^ sr[13];
    // Shift one bit per clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr           <= 23'h7FFFFF;
            rx_line_data <= 1'b0;
        end else begin
            sr           <= {sr[21:0], nb};
            rx_line_data <= ~nb ^ err; // Sent inverted
        end
    end
endmodule : ltps_framer_model

// file: testbench/ltps_top_monitor.sv
// Port checker of the line test pattern selector.
// Assumes it is bound to ltps_top and tracks the control bits from APB writes.
`timescale 1ns/1ps
`include "ltps_regs.svh"
module ltps_top_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_positive_rail,
    input wire logic        tx_negative_rail,
    input wire logic        line_tx_pos,
    input wire logic        line_tx_neg,
    input wire logic        pattern_detect_out,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] ctl;
    logic [4:0] age;
    logic       st;
    logic       lg;
    // Shadow of rate and select bits, with cycles since last write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 4'h0;
            age <= 5'h00;
        end else if (psel && penable && pready && pwrite && paddr == `LTPS_CTRL_OFS) begin
            ctl <= {pwdata[7:6], pwdata[3:2]};
            age <= 5'h00;
        end else if (age != 5'h1F) begin
            age <= age + 5'h01;
        end
    end
    assign st = age > 5'h05;
    assign lg = age == 5'h1F;
    property p_pass_pos;
        ctl[1:0] == 2'h0 && st |-> line_tx_pos == $past(tx_positive_rail, 3);
    endproperty
    a_pass_pos: assert property (p_pass_pos) else $error("pos rail not passed");
    property p_pass_neg;
        ctl[1:0] == 2'h0 && st |-> line_tx_neg == $past(tx_negative_rail, 3);
    endproperty
    a_pass_neg: assert property (p_pass_neg) else $error("neg rail not passed");
    property p_neg_low;
        ctl[1:0] != 2'h0 && st |-> !line_tx_neg;
    endproperty
    a_neg_low: assert property (p_neg_low) else $error("neg busy in pattern");
    property p_ones;
        ctl[1:0] == 2'h1 && (ctl[3] || !ctl[2]) && st |-> line_tx_pos;
    endproperty
    a_ones: assert property (p_ones) else $error("all ones broken");
    property p_p100_per;
        ctl[1:0] == 2'h2 && st |-> line_tx_pos == $past(line_tx_pos, 3);
    endproperty
    a_p100_per: assert property (p_p100_per) else $error("100100 period");
    property p_p100_one;
        ctl[1:0] == 2'h2 && st |->
            $countones({line_tx_pos, $past(line_tx_pos), $past(line_tx_pos, 2)}) == 1;
    endproperty
    a_p100_one: assert property (p_p100_one) else $error("100100 weight");
    property p_prbs15;
        ctl[1:0] == 2'h3 && !ctl[3] && lg |->
            line_tx_pos == ($past(line_tx_pos, 14) ~^ $past(line_tx_pos, 15));
    endproperty
    a_prbs15: assert property (p_prbs15) else $error("15-bit PRBS");
    property p_prbs23;
        ctl[1:0] == 2'h3 && ctl[3] && lg |->
            line_tx_pos == ($past(line_tx_pos, 18) ~^ $past(line_tx_pos, 23));
    endproperty
    a_prbs23: assert property (p_prbs23) else $error("23-bit PRBS");
    property p_ready;
        pready == (psel && penable);
    endproperty
    a_ready: assert property (p_ready) else $error("pready wrong"); // Zero wait
    c_lock: cover property ($rose(pattern_detect_out));
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
endmodule : ltps_top_monitor
bind ltps_top ltps_top_monitor u_ltps_top_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .tx_positive_rail, .tx_negative_rail, .line_tx_pos,
    .line_tx_neg, .pattern_detect_out, .irq);

// file: testbench/tb_top.sv
// Self-checking bench of the line test pattern selector.
// Assumes ltps_top with a short lock count and the framer model on the receive line.
`timescale 1ns/1ps
`include "ltps_regs.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %0h seen %0h", nm, e, a); end end
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, err, lpoly;
    logic        tx_positive_rail = 1'b0, tx_negative_rail = 1'b0;
    logic [7:0]  paddr, pm;
    logic [31:0] pwdata, prdata, e, q[$];
    logic [31:0] seed = 32'h00001A52;
    logic        pready, pslverr, rx_line_data, line_tx_pos, line_tx_neg;
    logic        pattern_detect_out, irq;
    logic [7:0]  md [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h4C, 8'h44, 8'h84, 8'h8C,
                             8'hC4, 8'hCC};
    int          n_mismatch = 0, n_checks = 0, cyc = 0, i, z;
    ltps_top #(.SYNC_GOOD(32)) u_ltps_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tx_positive_rail, .tx_negative_rail,
        .rx_line_data, .line_tx_pos, .line_tx_neg, .pattern_detect_out, .irq);
    ltps_framer_model u_ltps_framer_model (.pclk, .presetn, .long_poly(lpoly), .err,
        .rx_line_data);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // One APB transfer, zero or more wait states
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        `CHK("pslverr", a > `LTPS_INT_EN_OFS, pslverr)
        psel <= 1'b0; penable <= 1'b0;
        #1;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // Look at the detector only once its edge has settled
    task automatic wait_det(input logic v);
        #1;
        for (i = 0; i < 400 && pattern_detect_out !== v; i++) begin
            @(posedge pclk);
            #1;
        end
        `CHK("detect", v, pattern_detect_out)
    endtask : wait_det
    // Clock, random rails and timeout
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        seed <= xs(seed);
        {tx_positive_rail, tx_negative_rail} <= seed[1:0];
        cyc++;
        if (cyc == 20000) begin n_mismatch++; give_verdict(); end
    end
    // Read data checked against the oldest expectation
    always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
        e = q.pop_front();
        `CHK("prdata", e, prdata)
    end
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        err = 0; lpoly = 0; pm = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`LTPS_CTRL_OFS, 32'h0);
        wr_bad: apb(1'b1, 8'h14, 32'hFF);
        rd(8'h14, 32'h0);
        rd(`LTPS_INT_CLR_OFS, 32'h0);
        // Every select at DS3, the ones or alarm and PRBS selects at E3 and STS-1, select cleared before rates move
        foreach (md[k]) begin
            apb(1'b1, `LTPS_CTRL_OFS, pm & 8'hC0);
            apb(1'b1, `LTPS_CTRL_OFS, md[k] & 8'hC0);
            apb(1'b1, `LTPS_CTRL_OFS, md[k]);
            rd(`LTPS_CTRL_OFS, md[k]);
            z = 0;
            repeat (120) begin @(posedge pclk); z += !line_tx_pos; end
            if (md[k] == 8'h44) `CHK("ais_zeros", 1'b1, z > 0)
            pm = md[k];
        end
        // Detector, status and interrupt
        apb(1'b1, `LTPS_CTRL_OFS, 32'hC0);
        apb(1'b1, `LTPS_CTRL_OFS, 32'h80);
        repeat (200) @(posedge pclk);
        `CHK("detect_e3", 1'b0, pattern_detect_out)
        apb(1'b1, `LTPS_INT_CLR_OFS, 32'h7);
        apb(1'b1, `LTPS_INT_EN_OFS, 32'h1);
        `CHK("irq_idle", 1'b0, irq)
        apb(1'b1, `LTPS_CTRL_OFS, 32'h0);
        wait_det(1'b1);
        `CHK("irq_set", 1'b1, irq)
        rd(`LTPS_STATUS_OFS, 32'h1);
        rd(`LTPS_INT_STAT_OFS, 32'h1);
        apb(1'b1, `LTPS_INT_EN_OFS, 32'h0);
        `CHK("irq_mask", 1'b0, irq)
        apb(1'b1, `LTPS_INT_CLR_OFS, 32'h1);
        rd(`LTPS_INT_STAT_OFS, 32'h0);
        @(posedge pclk) lpoly <= 1'b1;
        apb(1'b1, `LTPS_CTRL_OFS, 32'h80);
        wait_det(1'b1);
        // Dense bit errors outrun the forgiveness after SYNC_GOOD matching bits
        repeat (8) begin
            @(posedge pclk) err <= 1'b1;
            @(posedge pclk) err <= 1'b0;
        end
        wait_det(1'b0);
        rd(`LTPS_INT_STAT_OFS, 32'h3);
        // Rate moved while a pattern runs raises the mode event
        apb(1'b1, `LTPS_CTRL_OFS, 32'h8C);
        apb(1'b1, `LTPS_CTRL_OFS, 32'h0C);
        rd(`LTPS_INT_STAT_OFS, 32'h7);
        give_verdict();
    end
endmodule : tb_top
